// file: hdl/rpss_top.sv
/*
  Reset pin-state sequencer: forces each pin group to its reset state
  while the external reset pin is low, releases the bidirectional group at once
  and the others after strap-dependent hold counts, toggles the clock outputs, and qualifies
  external interrupt pulses by width.
  Assumes the core supplies its normal pin drive and enables; the pad
  ring resolves the wires from the enables given here.
*/
// Overview of operation
// - Reset low tri-states the whole memory bus, first memory clock too.
// - Memory ready and bus-hold acknowledge are never tri-stated.
// - Memory bus released after 41115 or 148 input periods by strap.
// - Reset low drives ack, flag, I2C, UART and TDO high.
// - High group held for 41044 or 77 input periods after release.
// - Reset low tri-states host ready, host interrupt, both serial tx.
// - That group stays off 41044 or 77 input periods after release.
// - Reset low turns every bidirectional pin to input.
// - Second memory clock and system clock toggle during reset.
// - Pin states are defined from power-on reset, before the reset pin is seen.
// - Ack changes on CPU edges, lagging the quarter-rate clock 1-3.
`timescale 1ns/1ns
`default_nettype none

module rpss_top
  import rpss_pkg::*;
#(
  parameter int          IO_W        = 32,
  parameter int          CLKIN_DIV   = CLKIN_DIV_CYC,
  parameter logic [15:0] MEM_HOLD0   = MEM_HOLD_P_MODE0,
  parameter logic [15:0] MEM_HOLD1   = MEM_HOLD_P_MODE1,
  parameter logic [15:0] HIGH_HOLD0  = HIGH_HOLD_P_MODE0,
  parameter logic [15:0] HIGH_HOLD1  = HIGH_HOLD_P_MODE1,
  parameter logic [15:0] Z_HOLD0     = Z_HOLD_P_MODE0,
  parameter logic [15:0] Z_HOLD1     = Z_HOLD_P_MODE1
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             ext_reset_n,
  input  wire logic             strap_pin_four,
  input  wire logic             ext_int_n,
  input  wire logic             cpu_active,
  input  wire logic             memory_ready_in,
  input  wire logic             core_mem_oe,
  input  wire logic             core_hold_ack,
  input  wire rpss_high_t       core_high,
  input  wire logic [3:0]       core_z_oe,
  input  wire logic [IO_W-1:0]  core_io_oe,
  output logic                  mem_bus_oe,
  output logic                  memory_clock_out_a_oe,
  output logic                  memory_clock_out_b,
  output logic                  system_clock_out,
  output logic                  bus_hold_ack,
  output logic                  mem_ready_sync,
  output rpss_high_t            high_pins,
  output logic [3:0]            z_group_oe,
  output logic [IO_W-1:0]       bidir_oe,
  output rpss_ctl_t             group_ctl,
  output logic                  clock_mode_strap,
  output logic                  int_request
);

  // synchronisers for pins from outside the clock domain
  logic rst_m_r, rst_s_r, strap_m_r, strap_s_r;
  logic int_m_r, int_s_r, rdy_m_r, rdy_s_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rst_m_r   <= 1'b0;
      rst_s_r   <= 1'b0;
      strap_m_r <= 1'b0;
      strap_s_r <= 1'b0;
      int_m_r   <= 1'b1;
      int_s_r   <= 1'b1;
      rdy_m_r   <= 1'b0;
      rdy_s_r   <= 1'b0;
    end else begin
      rst_m_r   <= ext_reset_n;
      rst_s_r   <= rst_m_r;
      strap_m_r <= strap_pin_four;
      strap_s_r <= strap_m_r;
      int_m_r   <= ext_int_n;
      int_s_r   <= int_m_r;
      rdy_m_r   <= memory_ready_in;
      rdy_s_r   <= rdy_m_r;
    end
  end

  // input-clock period tick and quarter-rate clock divider
  logic [7:0] tick_cnt_r, tick_cnt_nxt;
  logic [7:0] sys_cnt_r, sys_cnt_nxt;
  logic       sysclk_r, sysclk_nxt;
  logic       tick;

  always_comb begin
    tick         = (tick_cnt_r == 8'(CLKIN_DIV - 1));
    tick_cnt_nxt = tick ? 8'h00 : tick_cnt_r + 8'h01;
    sys_cnt_nxt  = sys_cnt_r + 8'h01;
    sysclk_nxt   = sysclk_r;
    if (sys_cnt_r == 8'(SYSCLK_HALF_CYC - 1)) begin
      sys_cnt_nxt = 8'h00;
      sysclk_nxt  = ~sysclk_r;
    end
  end

  // dividers run from power-on so the clocks never wait for the sequencer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tick_cnt_r <= 8'h00;
      sys_cnt_r  <= 8'h00;
      sysclk_r   <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      sys_cnt_r  <= sys_cnt_nxt;
      sysclk_r   <= sysclk_nxt;
    end
  end

  // sequencer: reset, post-release hold, run
  rpss_state_t state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic        strap_r, strap_nxt;
  rpss_ctl_t   ctl_r, ctl_nxt;
  rpss_high_t  high_r, high_nxt;
  logic [15:0] mem_lim, high_lim, z_lim;

  always_comb begin
    mem_lim   = strap_r ? MEM_HOLD1  : MEM_HOLD0;
    high_lim  = strap_r ? HIGH_HOLD1 : HIGH_HOLD0;
    z_lim     = strap_r ? Z_HOLD1    : Z_HOLD0;
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    strap_nxt = strap_r;
    ctl_nxt   = ctl_r;
    case (state_r)
      ST_RESET: begin
        cnt_nxt = 16'h0000;
        ctl_nxt = '0;
        strap_nxt = strap_s_r;
        if (rst_s_r) begin
          state_nxt        = ST_HOLD;
          ctl_nxt.io_valid = 1'b1;
        end
      end
      ST_HOLD: begin
        if (tick && cnt_r != 16'hFFFF) begin
          cnt_nxt = cnt_r + 16'h0001;
        end
        ctl_nxt.mem_valid  = (cnt_r >= mem_lim);
        ctl_nxt.high_valid = (cnt_r >= high_lim);
        ctl_nxt.z_valid    = (cnt_r >= z_lim);
        if (ctl_r.mem_valid && ctl_r.high_valid && ctl_r.z_valid) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: ;
      default: state_nxt = ST_RESET;
    endcase
    // any reset low drops every group at once
    if (!rst_s_r) begin
      state_nxt = ST_RESET;
      ctl_nxt   = '0;
    end
    high_nxt = ctl_nxt.high_valid ? core_high :
               '{interrupt_ack_out: 1'b1, flag: 1'b1, uart_tx: 1'b1, tdo: 1'b1,
                 scl_oe: 1'b0, sda_oe: 1'b0};
  end

  // power-on reset gives defined levels before the pin is seen
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= ST_RESET;
      cnt_r   <= 16'h0000;
      strap_r <= 1'b0;
      ctl_r   <= '0;
      high_r  <= '{interrupt_ack_out: 1'b1, flag: 1'b1, uart_tx: 1'b1, tdo: 1'b1,
                   scl_oe: 1'b0, sda_oe: 1'b0};
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      strap_r <= strap_nxt;
      ctl_r   <= ctl_nxt;
      // ack moves only on CPU clock edges
      high_r  <= high_nxt;
    end
  end

  // external interrupt width qualification
  logic [1:0] low_cnt_r, low_cnt_nxt;
  logic       armed_r, armed_nxt;
  logic       req_r, req_nxt;

  always_comb begin
    low_cnt_nxt = low_cnt_r;
    armed_nxt   = armed_r;
    req_nxt     = 1'b0;
    if (int_s_r) begin
      low_cnt_nxt = 2'h0;
      if (INT_HIGH_MIN_CYC == 2'h1) begin
        armed_nxt = 1'b1;
      end
    end else begin
      if (low_cnt_r != 2'h3) begin
        low_cnt_nxt = low_cnt_r + 2'h1;
      end
      if (armed_r && cpu_active && low_cnt_r == INT_LOW_MIN_CYC - 2'h1) begin
        req_nxt   = 1'b1;
        armed_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      low_cnt_r <= 2'h0;
      armed_r   <= 1'b0;
      req_r     <= 1'b0;
    end else begin
      low_cnt_r <= low_cnt_nxt;
      armed_r   <= armed_nxt;
      req_r     <= req_nxt;
    end
  end

  // pin gating; enables may be combinational, levels come from flops except bus_hold_ack
  // memory bus and first memory clock
  assign mem_bus_oe            = core_mem_oe & ctl_r.mem_valid;
  assign memory_clock_out_a_oe = ctl_r.mem_valid;
  // ungated members of the memory group; neither has an enable
  assign bus_hold_ack          = core_hold_ack;
  assign mem_ready_sync        = rdy_s_r;
  assign z_group_oe            = core_z_oe & {4{ctl_r.z_valid}};
  assign bidir_oe              = core_io_oe & {IO_W{ctl_r.io_valid}};
  assign memory_clock_out_b    = sysclk_r;
  assign system_clock_out      = sysclk_r;
  assign high_pins             = high_r;
  assign group_ctl             = ctl_r;
  assign clock_mode_strap      = strap_r;
  assign int_request           = req_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_low_three;
    !int_s_r [*3];
  endsequence
  sequence s_release;
    (state_r == ST_RESET) ##1 (state_r == ST_HOLD);
  endsequence

  a_mem_hiz_reset: assert property (!rst_s_r |=> !mem_bus_oe &&
      !memory_clock_out_a_oe) else $error("memory bus driven in reset");
  a_ready_not_hiz: assert property (bus_hold_ack == core_hold_ack
      && mem_ready_sync == $past(rdy_m_r)) else $error("ready/hold gated");
  a_mem_hold_cnt: assert property ($rose(ctl_r.mem_valid) |->
      $past(cnt_r) >= $past(mem_lim) && $past(cnt_r) <= $past(mem_lim) + 16'h1)
      else $error("memory bus released at wrong count");
  a_high_forced: assert property (!ctl_r.high_valid |-> high_pins.interrupt_ack_out
      && high_pins.flag && high_pins.uart_tx && high_pins.tdo
      && !high_pins.scl_oe && !high_pins.sda_oe)
      else $error("high group not at reset level");
  a_high_hold_cnt: assert property ($rose(ctl_r.high_valid) |->
      $past(cnt_r) >= $past(high_lim)) else $error("high group early");
  a_z_hiz: assert property (!ctl_r.z_valid |-> z_group_oe == 4'h0)
      else $error("z group driven while held");
  a_z_hold_cnt: assert property ($rose(ctl_r.z_valid) |->
      $past(cnt_r) >= $past(z_lim)) else $error("z group early");
  a_io_input: assert property (!rst_s_r |=> bidir_oe == '0)
      else $error("bidirectional pin driven in reset");
  a_toggle_run: assert property (!rst_s_r |-> ##[1:2]
      $changed(system_clock_out)) else $error("clock outputs stalled");
  a_int_width: assert property (int_request |->
      $past(!int_s_r, 1) && $past(!int_s_r, 2) && $past(!int_s_r, 3))
      else $error("interrupt accepted too short");
  a_int_rearm: assert property (s_low_three ##1 int_request ##1
      !int_s_r [*4] |-> !int_request) else $error("request without high gap");
  a_strap_latch: assert property (s_release |->
      clock_mode_strap == $past(strap_s_r)) else $error("strap not latched");

endmodule : rpss_top

`default_nettype wire

// file: hdl/rpss_pkg.sv
/*
  Package for the reset pin-state sequencer: timing counts, pin group
  carriers and sequencer states.
  Assumes a 100 MHz CPU clock. The input clock pin is modelled as a fixed
  ratio of that clock.
*/
package rpss_pkg;

  // clock figures in ns
  localparam int CLK_PERIOD_NS   = 10;
  localparam int CLKIN_PERIOD_NS = 50;
  localparam int CLKIN_DIV_CYC   = CLKIN_PERIOD_NS / CLK_PERIOD_NS;

  // post-release hold counts in input-clock periods, per strap value
  localparam logic [15:0] MEM_HOLD_P_MODE0  = 16'hA09B; // 41115
  localparam logic [15:0] MEM_HOLD_P_MODE1  = 16'h0094; // 148
  localparam logic [15:0] HIGH_HOLD_P_MODE0 = 16'hA054; // 41044
  localparam logic [15:0] HIGH_HOLD_P_MODE1 = 16'h004D; // 77
  localparam logic [15:0] Z_HOLD_P_MODE0    = 16'hA054; // 41044
  localparam logic [15:0] Z_HOLD_P_MODE1    = 16'h004D; // 77

  // toggle group must run within this many input periods of reset
  localparam int TGL_LIMIT_P      = 14;
  // visible system clock is a quarter of the CPU clock
  localparam int SYSCLK_DIV       = 4;
  localparam int SYSCLK_HALF_CYC  = SYSCLK_DIV / 2;

  // external interrupt widths in CPU clocks
  localparam logic [1:0] INT_LOW_MIN_CYC  = 2'h3;
  localparam logic [1:0] INT_HIGH_MIN_CYC = 2'h1;

  // group release flags
  typedef struct packed {
    logic mem_valid;
    logic high_valid;
    logic z_valid;
    logic io_valid;
  } rpss_ctl_t;

  // high-level pin group; open-drain lines carry a drive-low enable
  typedef struct packed {
    logic interrupt_ack_out;
    logic flag;
    logic uart_tx;
    logic tdo;
    logic scl_oe;
    logic sda_oe;
  } rpss_high_t;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_HOLD  = 2'b01,
    ST_RUN   = 2'b10
  } rpss_state_t;

endpackage : rpss_pkg

// file: dv/rpss_board_model.sv
/*
  Board-side model: reset source and external interrupt source.
  Assumes the bench commands it at the falling clock edge; the model
  answers on the rising edge so the command is never raced.
*/
`timescale 1ns/1ns
`default_nettype none

module rpss_board_model #(
  parameter int RST_MIN = 5
) (
  input  wire logic       clk,
  input  wire logic       rst_hold,
  input  wire logic       int_go,
  input  wire logic [3:0] int_len,
  output logic            ext_reset_n,
  output logic            ext_int_n
);
  logic rst_pin_r = 1'b0;
  logic int_pin_r = 1'b1;
  int   low_cnt   = 0;
  int   int_cnt   = 0;
  assign ext_reset_n = rst_pin_r;
  assign ext_int_n   = int_pin_r;
  // low pulse never shorter than the minimum width
  always @(posedge clk) begin
    if (rst_hold && rst_pin_r) begin
      rst_pin_r <= 1'b0;
      low_cnt <= 1;
    end else if (!rst_pin_r) begin
      low_cnt <= low_cnt + 1;
      if (!rst_hold && low_cnt >= RST_MIN) rst_pin_r <= 1'b1;
    end
  end
  // low for exactly int_len cycles, then high
  always @(posedge clk) begin
    if (int_go && int_cnt == 0) begin
      int_pin_r <= 1'b0;
      int_cnt <= int_len;
    end else if (int_cnt > 1) begin
      int_cnt <= int_cnt - 1;
    end else if (int_cnt == 1) begin
      int_pin_r <= 1'b1;
      int_cnt <= 0;
    end
  end
endmodule : rpss_board_model

`default_nettype wire

// file: dv/tb_rpss_top.sv
/*
  Self-checking bench for the reset pin-state sequencer.
  Assumes shortened strap-0 counts and a 2-cycle input clock.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_rpss_top;
  import rpss_pkg::*;
  localparam int D = 2;
  logic clk = 0, rstn = 0, strap = 0, cpu_act = 0, rdy = 0, hack = 0;
  logic rst_hold = 1, int_go = 0;
  logic [3:0] int_len = 4'h3;
  logic core_mem_en = 1'h1;
  logic [3:0] core_z_en = 4'hF;
  logic [31:0] core_io_en = 32'hFFFFFFFF;
  logic ext_reset_n, ext_int_n, mem_oe, mca_oe, mcb, sclk, hold_ack;
  logic rdy_s, strap_l, int_req;
  logic [3:0] z_oe;
  logic [31:0] io_oe;
  rpss_high_t core_high = '0, high_pins;
  rpss_ctl_t ctl;
  int failures = 0, check_count = 0;

  initial forever #5 clk = ~clk;

  rpss_board_model #(.RST_MIN(2 * D + 1)) rpss_board_model_i (.clk(clk),
    .rst_hold(rst_hold), .int_go(int_go), .int_len(int_len),
    .ext_reset_n(ext_reset_n), .ext_int_n(ext_int_n));

  rpss_top #(.CLKIN_DIV(D), .MEM_HOLD0(16'h0028), .HIGH_HOLD0(16'h0014),
    .Z_HOLD0(16'h0014)) rpss_top_i (.clk(clk), .rstn(rstn),
    .ext_reset_n(ext_reset_n), .strap_pin_four(strap), .ext_int_n(ext_int_n),
    .cpu_active(cpu_act), .memory_ready_in(rdy), .core_mem_oe(core_mem_en),
    .core_hold_ack(hack), .core_high(core_high), .core_z_oe(core_z_en),
    .core_io_oe(core_io_en), .mem_bus_oe(mem_oe),
    .memory_clock_out_a_oe(mca_oe), .memory_clock_out_b(mcb),
    .system_clock_out(sclk), .bus_hold_ack(hold_ack), .mem_ready_sync(rdy_s),
    .high_pins(high_pins), .z_group_oe(z_oe), .bidir_oe(io_oe),
    .group_ctl(ctl), .clock_mode_strap(strap_l), .int_request(int_req));

  // one comparison; an unknown bit matches only an unknown bit in the expected value
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (failures == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // reset pin low: every group forced, clocks still running
  task automatic t_reset_state();
    int n;
    logic prev;
    n = 0;
    rst_hold = 1;
    repeat (6) @(negedge clk);
    check(mem_oe, 0);
    check(mca_oe, 0);
    check(high_pins, 6'h3C);
    check(z_oe, 0);
    check(io_oe, 0);
    check(ctl, 0);
    hack = ~hack;
    rdy = ~rdy;
    repeat (3) @(negedge clk);
    check(hold_ack, hack);
    check(rdy_s, rdy);
    // count edges: quarter-rate clock flips every two cycles
    prev = sclk;
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      if (sclk !== prev) n++;
      prev = sclk;
      check(mcb, sclk);
    end
    check(n, 4);
  endtask : t_reset_state

  // release and time the held groups against the strap-selected counts, the bidirectional group against 3 to 6 cycles
  task automatic t_release(input logic s, input int lm, input int lh);
    int ti, th, tz, tm;
    ti = -1; th = -1; tz = -1; tm = -1;
    strap = s;
    rst_hold = 0;
    for (int k = 1; k < 400; k++) begin
      @(negedge clk);
      if (k == 12) strap = ~s;
      if (ti < 0 && ctl.io_valid) ti = k;
      if (th < 0 && ctl.high_valid) th = k;
      if (tz < 0 && ctl.z_valid) tz = k;
      if (tm < 0 && ctl.mem_valid) tm = k;
      if (k == lh * D - 2) check(high_pins, 6'h3C);
      if (k == lh * D - 2) check(z_oe, 0);
    end
    check(strap_l, s);
    check(ti >= 3 && ti <= 6, 1);
    check(th >= lh * D && th <= lh * D + D + 8, 1);
    check(tz, th);
    check(tm >= lm * D && tm <= lm * D + D + 8, 1);
    check(high_pins, core_high);
    check({mem_oe, z_oe, io_oe[0]}, 6'h3F);
    // core enables pass straight through once released
    core_mem_en = 1'h0;
    core_z_en   = 4'h5;
    core_io_en  = 32'h5A5A5A5A;
    @(negedge clk);
    check(mem_oe, 0);
    check(z_oe, 4'h5);
    check(io_oe, 32'h5A5A5A5A);
    core_mem_en = 1'h1;
    core_z_en   = 4'hF;
    core_io_en  = 32'hFFFFFFFF;
  endtask : t_release

  // reset falls in mid-hold: groups go back at once
  task automatic t_abort();
    strap = 1;
    rst_hold = 0;
    repeat (60) @(negedge clk);
    check({ctl.io_valid, ctl.mem_valid, ctl.high_valid}, 3'h4);
    t_reset_state();
  endtask : t_abort

  // one pulse of given width; count requests seen
  task automatic t_int(input logic [3:0] len, input logic act, input int e);
    int n;
    n = 0;
    cpu_act = act;
    int_len = len;
    int_go = 1;
    @(negedge clk);
    int_go = 0;
    repeat (14) begin
      @(negedge clk);
      if (int_req === 1'b1) n++;
    end
    check(n, e);
  endtask : t_int

  // acknowledge output follows the core within three cycles
  task automatic t_interrupt_ack_out();
    core_high.interrupt_ack_out = 1'b1;
    repeat (3) @(negedge clk);
    check(high_pins.interrupt_ack_out, 1);
  endtask : t_interrupt_ack_out

  initial begin
    repeat (4) @(negedge clk);
    rstn = 1;
    t_reset_state();
    t_abort();
    t_release(0, 40, 20);
    t_reset_state();
    t_release(1, 148, 77);
    t_int(4'h3, 1, 1);
    t_int(4'h2, 1, 0);
    t_int(4'h5, 0, 0);
    t_int(4'h4, 1, 1);
    // long pulse: only one request until the pin returns high
    t_int(4'h8, 1, 1);
    t_interrupt_ack_out();
    print_verdict();
  end

  // hang guard, far beyond the planned run
  initial begin
    repeat (6000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule : tb_rpss_top

`default_nettype wire
